//--- pkg/azr_pkg.sv
// Purpose: constants for the alarm zone report encoder
// Assumes: 10 MHz clock, inputs synchronous to clk
// Notes: high-speed messages are 9 digits, zone 1 first, status last
//
// Overview of operation
// - keypad mode: panel lost reports 0000
// - tamper reports 0880, link loss 0005
// - unregistered reports 000F, shutdown 0019
// - after power-on: 0400, 0C80, 0C8F combinations
// - each status also sent as station event
// - shared input: pulsed zone 1, steady zone 2
// - pulsed only after three counted pulses
// - panic option: single pulse alarms zone 3
// - panic zone never sends restore
// - zones 3 to 7 are level inputs
// - dual emulation answers two consecutive addresses
// - four relay-zones single, eight dual
// - second module relays map zones 5-8
// - arm-only selected: top zone arms, unreported
// - dual with tamper reporting hides zone 8
// - per zone restore, delay, arm-only options
// - momentary relay: alarm, never restore
// - zone reports status 7, digit 1/3
// - no panel activity: supervision trouble, restore
package azr_pkg;
  // ********************************
  // timing
  // ********************************
  localparam int CLK_HZ = 10_000_000;
  localparam int MS_CYC = CLK_HZ / 1000;
  localparam int SEC_MS = 1000;
  localparam int MOMENT_MS = 500;
  localparam int SUP_MS = 60000;
  localparam int PULSE_MS = 500;
  localparam int GAP_MS = 2000;
  localparam int SEC_CYC = SEC_MS * MS_CYC;
  localparam int MOMENT_CYC = MOMENT_MS * MS_CYC;
  localparam int SUP_CYC = SUP_MS * MS_CYC;
  localparam int PULSE_CYC = PULSE_MS * MS_CYC;
  localparam int GAP_CYC = GAP_MS * MS_CYC;
  // ********************************
  // codes and layout
  // ********************************
  localparam logic [15:0] ST_PANEL_LOST = 16'h0000;
  localparam logic [15:0] ST_TAMPER = 16'h0880;
  localparam logic [15:0] ST_LINK_LOST = 16'h0005;
  localparam logic [15:0] ST_NOT_REG = 16'h000F;
  localparam logic [15:0] ST_SHUTDOWN = 16'h0019;
  localparam logic [15:0] ST_POR_PANEL = 16'h0400;
  localparam logic [15:0] ST_POR_TAMPER = 16'h0C80;
  localparam logic [15:0] ST_POR_TAMP_REG = 16'h0C8F;
  localparam logic [3:0] DIG_ALARM = 4'h1;
  localparam logic [3:0] DIG_RESTORE = 4'h3;
  localparam logic [3:0] DIG_IDLE = 4'h5;
  localparam logic [3:0] EVT_ZONE = 4'h7;
  localparam logic [3:0] EVT_SUP = 4'h5;
  localparam int NZONE = 8;
  localparam int RELAYS = 4;
  localparam int SUP_POS = 6;
  localparam int Z_FIRE = 0;
  localparam int Z_BURG = 1;
  localparam int Z_PANIC = 2;
  localparam logic [1:0] FIRE_PULSES = 2'h3;
  localparam logic [1:0] HOLD_LONG = 2'h2;
  localparam logic [35:0] SUP_TROUBLE = 36'h5555_5515_5;
  localparam logic [35:0] SUP_RESTORE = 36'h5555_5535_5;
  typedef enum logic [1:0] {
    AZR_KEYPAD = 2'b00,
    AZR_ZONE_TRIG = 2'b01,
    AZR_RELAY_ONE = 2'b10,
    AZR_RELAY_TWO = 2'b11
  } azr_mode_type;
  typedef enum logic [1:0] {
    AZR_CLS_LOW = 2'b00,
    AZR_CLS_HIGH = 2'b01,
    AZR_CLS_STEADY = 2'b10
  } azr_cls_type;
endpackage

//--- pkg/azr_pulse_if.sv
// Purpose: carries shared-input classification to the encoder
// Assumes: single clock domain
// Notes: fire and panic are one-cycle pulses, steady is a level
`timescale 1ns/1ns
interface azr_pulse_if;
  logic fire_evt;
  logic panic_evt;
  logic steady;
  modport cls (output fire_evt, output panic_evt, output steady);
  modport use_side (input fire_evt, input panic_evt, input steady);
endinterface

//--- hw/azr_pulse_classifier.sv
// Purpose: classify the shared zone 1/2 input as pulsed or steady
// Assumes: sig synchronous to clk
// Notes: a high longer than the pulse limit counts as steady
`timescale 1ns/1ns
module azr_pulse_classifier #(
  parameter int PULSE_P = azr_pkg::PULSE_CYC,
  parameter int GAP_P = azr_pkg::GAP_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sig,
  input wire logic panic_en,
  azr_pulse_if.cls pl
);
  typedef struct packed {
    azr_pkg::azr_cls_type st;
    logic [31:0] cnt;
    logic [1:0] pc;
    logic fire;
    logic panic;
    logic steady;
  } azr_cls_state_type;
  azr_cls_state_type s;
  azr_cls_state_type next_s;

  always_comb begin
    next_s = s;
    next_s.fire = 1'b0;
    next_s.panic = 1'b0;
    case (s.st)
      azr_pkg::AZR_CLS_LOW: begin
        if (sig) begin
          next_s.st = azr_pkg::AZR_CLS_HIGH;
          next_s.cnt = '0;
        end else if (s.pc != 2'h0) begin
          next_s.cnt = s.cnt + 32'h1;
          // gap closes a burst: lone pulse is panic
          if (s.cnt >= 32'(GAP_P - 1)) begin
            next_s.panic = panic_en && (s.pc == 2'h1);
            next_s.pc = 2'h0;
            next_s.cnt = '0;
          end
        end
      end
      azr_pkg::AZR_CLS_HIGH: begin
        if (!sig) begin
          next_s.st = azr_pkg::AZR_CLS_LOW;
          next_s.cnt = '0;
          next_s.pc = s.pc + 2'h1;
          if (s.pc + 2'h1 == azr_pkg::FIRE_PULSES) begin
            next_s.fire = 1'b1;
            next_s.pc = 2'h0;
          end
        end else begin
          next_s.cnt = s.cnt + 32'h1;
          if (s.cnt >= 32'(PULSE_P - 1)) begin
            next_s.st = azr_pkg::AZR_CLS_STEADY;
            next_s.steady = 1'b1;
            next_s.pc = 2'h0;
          end
        end
      end
      azr_pkg::AZR_CLS_STEADY: begin
        if (!sig) begin
          next_s.st = azr_pkg::AZR_CLS_LOW;
          next_s.steady = 1'b0;
          next_s.cnt = '0;
        end
      end
      default: next_s.st = azr_pkg::AZR_CLS_LOW;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pl.fire_evt = s.fire;
  assign pl.panic_evt = s.panic;
  assign pl.steady = s.steady;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  fire_third_pulse_a: assert property (s.fire |-> $past(s.pc) == 2'h2 && $past(s.st) == azr_pkg::AZR_CLS_HIGH)
    else $error("fire without third pulse");
  steady_level_a: assert property (s.steady |-> $past(sig))
    else $error("steady while input low");
endmodule // azr_pulse_classifier

//--- hw/azr_encoder.sv
// Purpose: status codes, zone classification and high-speed zone reports
// Assumes: all inputs synchronous to clk; bus decoding done upstream
// Notes: one high-speed message per cycle at most, no back-pressure
`timescale 1ns/1ns
module azr_encoder #(
  parameter int SEC_P = azr_pkg::SEC_CYC,
  parameter int MOMENT_P = azr_pkg::MOMENT_CYC,
  parameter int SUP_P = azr_pkg::SUP_CYC,
  parameter int PULSE_P = azr_pkg::PULSE_CYC,
  parameter int GAP_P = azr_pkg::GAP_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire azr_pkg::azr_mode_type mode,
  input wire logic panel_lost,
  input wire logic tamper,
  input wire logic link_lost,
  input wire logic not_registered,
  input wire logic shutdown,
  input wire logic por_clear,
  input wire logic shared_in,
  input wire logic [4:0] zone_in,
  input wire logic panic_en,
  input wire logic [4:0] dev_addr,
  input wire logic [4:0] bus_addr,
  input wire logic bus_wr,
  input wire logic [3:0] bus_data,
  input wire logic bus_activity,
  input wire logic [7:0] restore_en,
  input wire logic [7:0] arm_only,
  input wire logic [31:0] zone_delay,
  input wire logic tamper_rpt_en,
  output logic [15:0] long_range_status_display,
  output logic status_valid,
  output logic [15:0] event_code,
  output logic event_valid,
  output logic [35:0] hs_msg,
  output logic hs_valid,
  output logic sup_fault
);
  // ********************************
  // state
  // ********************************
  typedef struct packed {
    logic [15:0] stat_code;
    logic stat_valid;
    logic [15:0] evt_code;
    logic evt_valid;
    logic por;
    logic [7:0] relay;
    logic [7:0] lvl_q;
    logic [7:0][1:0] hold;
    logic [7:0] apend;
    logic [7:0] rpend;
    logic [7:0][3:0] dly;
    logic [31:0] sec_cnt;
    logic [31:0] mom_cnt;
    logic [31:0] sup_cnt;
    logic sup_fault;
    logic sup_tpend;
    logic sup_rpend;
    logic [35:0] hs_msg;
    logic hs_valid;
  } azr_state_type;
  azr_state_type s;
  azr_state_type next_s;

  azr_pulse_if pl ();

  azr_pulse_classifier #(
    .PULSE_P(PULSE_P),
    .GAP_P(GAP_P)
  ) u_cls (
    .clk(clk),
    .sys_rst(sys_rst),
    .sig(shared_in),
    .panic_en(panic_en),
    .pl(pl.cls)
  );

  // all positions idle except the one carrying the event
  function automatic logic [35:0] azr_msg(input int pos, input logic [3:0] dig, input logic [3:0] st);
    logic [35:0] m;
    m = '0;
    for (int k = 0; k < azr_pkg::NZONE; k++) begin
      m[35 - 4 * k -: 4] = (k == pos) ? dig : azr_pkg::DIG_IDLE;
    end
    m[3:0] = st;
    return m;
  endfunction

  // ********************************
  // zone levels per mode
  // ********************************
  logic [7:0] zl;
  logic [7:0] zmask;
  logic [7:0] fire_pulse;
  logic relay_mode;
  logic two;
  int hi;
  genvar gz;
  generate
    for (gz = 0; gz < azr_pkg::NZONE; gz++) begin : g_zone
      always_comb begin
        zmask[gz] = 1'b0;
        zl[gz] = 1'b0;
        fire_pulse[gz] = 1'b0;
        case (mode)
          azr_pkg::AZR_ZONE_TRIG: begin
            zmask[gz] = (gz < 7);
            if (gz == azr_pkg::Z_BURG) begin
              zl[gz] = pl.steady;
            end else if (gz == azr_pkg::Z_PANIC) begin
              zl[gz] = !panic_en && zone_in[0];
              fire_pulse[gz] = panic_en && pl.panic_evt;
            end else if (gz > azr_pkg::Z_PANIC && gz < 7) begin
              zl[gz] = zone_in[(gz + 3) % 5];
            end else if (gz == azr_pkg::Z_FIRE) begin
              fire_pulse[gz] = pl.fire_evt;
            end
          end
          azr_pkg::AZR_RELAY_ONE: begin
            zmask[gz] = (gz < azr_pkg::RELAYS);
            zl[gz] = s.relay[gz] && (gz < azr_pkg::RELAYS);
          end
          azr_pkg::AZR_RELAY_TWO: begin
            zmask[gz] = 1'b1;
            zl[gz] = s.relay[gz];
          end
          default: begin
            zmask[gz] = 1'b0;
          end
        endcase
      end
    end
  endgenerate

  assign relay_mode = (mode == azr_pkg::AZR_RELAY_ONE) || (mode == azr_pkg::AZR_RELAY_TWO);
  assign two = (mode == azr_pkg::AZR_RELAY_TWO);
  assign hi = two ? 7 : 3;

  // ********************************
  // next state
  // ********************************
  logic sec_tick;
  logic mom_tick;
  logic [15:0] code;
  logic code_ok;
  logic arm_sel;
  logic armed;
  logic hide_hi;
  logic sent;
  logic [7:0] zok;

  always_comb begin
    next_s = s;
    next_s.hs_valid = 1'b0;
    next_s.evt_valid = 1'b0;
    sent = 1'b0;
    code = azr_pkg::ST_PANEL_LOST;
    code_ok = 1'b1;
    arm_sel = 1'b0;
    zok = '0;

    sec_tick = (s.sec_cnt >= 32'(SEC_P - 1));
    mom_tick = (s.mom_cnt >= 32'(MOMENT_P - 1));
    next_s.sec_cnt = sec_tick ? '0 : s.sec_cnt + 32'h1;
    next_s.mom_cnt = mom_tick ? '0 : s.mom_cnt + 32'h1;
    if (por_clear) begin
      next_s.por = 1'b0;
    end

    // keypad status, most severe first
    if (shutdown) begin
      code = azr_pkg::ST_SHUTDOWN;
    end else if (s.por && tamper && not_registered) begin
      code = azr_pkg::ST_POR_TAMP_REG;
    end else if (s.por && tamper) begin
      code = azr_pkg::ST_POR_TAMPER;
    end else if (s.por && panel_lost) begin
      code = azr_pkg::ST_POR_PANEL;
    end else if (panel_lost) begin
      code = azr_pkg::ST_PANEL_LOST;
    end else if (tamper) begin
      code = azr_pkg::ST_TAMPER;
    end else if (link_lost) begin
      code = azr_pkg::ST_LINK_LOST;
    end else if (not_registered) begin
      code = azr_pkg::ST_NOT_REG;
    end else begin
      code_ok = 1'b0;
    end
    next_s.stat_valid = code_ok && (mode == azr_pkg::AZR_KEYPAD);
    next_s.stat_code = next_s.stat_valid ? code : s.stat_code;
    // station event only on a new status
    if (next_s.stat_valid && (!s.stat_valid || code != s.stat_code)) begin
      next_s.evt_valid = 1'b1;
      next_s.evt_code = code;
    end

    // relay writes from the panel bus
    if (bus_wr && relay_mode) begin
      if (bus_addr == dev_addr) begin
        next_s.relay[3:0] = bus_data;
      end else if (two && bus_addr == dev_addr + 5'h1) begin
        next_s.relay[7:4] = bus_data;
      end
    end

    // arming: top relay-zone becomes the armed trigger
    for (int i = 0; i < azr_pkg::NZONE; i++) begin
      if (i < hi) begin
        arm_sel = arm_sel | arm_only[i];
      end
    end
    arm_sel = arm_sel && relay_mode;
    armed = zl[hi];
    hide_hi = arm_sel || (two && tamper_rpt_en);
    for (int i = 0; i < azr_pkg::NZONE; i++) begin
      zok[i] = zmask[i] && !(relay_mode && i == hi && hide_hi) && (!arm_only[i] || !arm_sel || armed);
    end

    // supervision of the panel connection
    if (relay_mode) begin
      if (bus_activity) begin
        next_s.sup_cnt = '0;
        if (s.sup_fault) begin
          next_s.sup_fault = 1'b0;
          next_s.sup_rpend = 1'b1;
        end
      end else if (s.sup_cnt >= 32'(SUP_P - 1)) begin
        if (!s.sup_fault) begin
          next_s.sup_fault = 1'b1;
          next_s.sup_tpend = 1'b1;
        end
      end else begin
        next_s.sup_cnt = s.sup_cnt + 32'h1;
      end
    end else begin
      next_s.sup_cnt = '0;
    end

    // sender: supervision first, then alarms, then restores
    if (s.sup_tpend) begin
      next_s.hs_msg = azr_msg(azr_pkg::SUP_POS, azr_pkg::DIG_ALARM, azr_pkg::EVT_SUP);
      next_s.hs_valid = 1'b1;
      next_s.sup_tpend = 1'b0;
      sent = 1'b1;
    end else if (s.sup_rpend) begin
      next_s.hs_msg = azr_msg(azr_pkg::SUP_POS, azr_pkg::DIG_RESTORE, azr_pkg::EVT_SUP);
      next_s.hs_valid = 1'b1;
      next_s.sup_rpend = 1'b0;
      sent = 1'b1;
    end
    for (int i = 0; i < azr_pkg::NZONE; i++) begin
      if (!sent && s.apend[i] && s.dly[i] == 4'h0) begin
        next_s.hs_msg = azr_msg(i, azr_pkg::DIG_ALARM, azr_pkg::EVT_ZONE);
        next_s.hs_valid = 1'b1;
        next_s.apend[i] = 1'b0;
        sent = 1'b1;
      end
    end
    for (int i = 0; i < azr_pkg::NZONE; i++) begin
      if (!sent && s.rpend[i]) begin
        next_s.hs_msg = azr_msg(i, azr_pkg::DIG_RESTORE, azr_pkg::EVT_ZONE);
        next_s.hs_valid = 1'b1;
        next_s.rpend[i] = 1'b0;
        sent = 1'b1;
      end
    end

    // zone edges after the sender so a new event wins over a clear
    for (int i = 0; i < azr_pkg::NZONE; i++) begin
      next_s.lvl_q[i] = zl[i];
      if (s.apend[i] && s.dly[i] != 4'h0 && sec_tick) begin
        next_s.dly[i] = s.dly[i] - 4'h1;
      end
      if (zl[i] && !s.lvl_q[i]) begin
        next_s.hold[i] = 2'h0;
      end else if (zl[i] && mom_tick && s.hold[i] != azr_pkg::HOLD_LONG) begin
        next_s.hold[i] = s.hold[i] + 2'h1;
      end
      if ((fire_pulse[i] || (zl[i] && !s.lvl_q[i])) && zok[i]) begin
        next_s.apend[i] = 1'b1;
        next_s.dly[i] = zone_delay[4 * i +: 4];
      end
      if (!zl[i] && s.lvl_q[i]) begin
        // a drop inside the delay cancels the pending alarm
        if (s.apend[i] && s.dly[i] != 4'h0) begin
          next_s.apend[i] = 1'b0;
        end else if (restore_en[i] && zok[i] && s.hold[i] == azr_pkg::HOLD_LONG) begin
          next_s.rpend[i] = 1'b1;
        end
      end
    end
    // panic zone carries no level, so no restore is ever queued
    if (mode == azr_pkg::AZR_ZONE_TRIG && panic_en) begin
      next_s.rpend[azr_pkg::Z_PANIC] = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s <= '0;
      s.por <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ********************************
  // outputs
  // ********************************
  assign long_range_status_display = s.stat_code;
  assign status_valid = s.stat_valid;
  assign event_code = s.evt_code;
  assign event_valid = s.evt_valid;
  assign hs_msg = s.hs_msg;
  assign hs_valid = s.hs_valid;
  assign sup_fault = s.sup_fault;

  // ********************************
  // checks
  // ********************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence sup_trip_s;
    !s.sup_fault ##1 s.sup_fault;
  endsequence
  sequence sup_clear_s;
    s.sup_fault ##1 !s.sup_fault;
  endsequence

  shutdown_code_a: assert property (mode == azr_pkg::AZR_KEYPAD && shutdown |=> status_valid && long_range_status_display == azr_pkg::ST_SHUTDOWN)
    else $error("shutdown code wrong");
  tamper_code_a: assert property (mode == azr_pkg::AZR_KEYPAD && tamper && !shutdown && !s.por && !panel_lost |=> long_range_status_display == azr_pkg::ST_TAMPER)
    else $error("tamper code wrong");
  panel_lost_a: assert property (mode == azr_pkg::AZR_KEYPAD && panel_lost && !shutdown && !s.por |=> long_range_status_display == azr_pkg::ST_PANEL_LOST)
    else $error("panel lost code wrong");
  por_combo_a: assert property (mode == azr_pkg::AZR_KEYPAD && s.por && tamper && not_registered && !shutdown |=> long_range_status_display == azr_pkg::ST_POR_TAMP_REG)
    else $error("power-on combined code wrong");
  event_code_a: assert property (event_valid |-> status_valid && event_code == long_range_status_display)
    else $error("station event differs from status");
  zone_status_a: assert property (hs_valid && hs_msg[3:0] != azr_pkg::EVT_SUP |-> hs_msg[3:0] == azr_pkg::EVT_ZONE)
    else $error("zone report status not 7");
  sup_trouble_a: assert property (sup_trip_s |=> hs_valid && hs_msg == azr_pkg::SUP_TROUBLE)
    else $error("supervision trouble not sent");
  sup_restore_a: assert property (sup_clear_s |=> hs_valid && hs_msg == azr_pkg::SUP_RESTORE)
    else $error("supervision restore not sent");
  panic_restore_a: assert property (hs_valid && mode == azr_pkg::AZR_ZONE_TRIG && panic_en |-> hs_msg[27:24] != azr_pkg::DIG_RESTORE)
    else $error("restore sent for panic zone");
  zone8_hidden_a: assert property (hs_valid && $past(two && tamper_rpt_en, 2) && two && tamper_rpt_en && hs_msg[3:0] == azr_pkg::EVT_ZONE |-> hs_msg[7:4] == azr_pkg::DIG_IDLE)
    else $error("zone 8 reported with tamper reporting");
  second_module_a: assert property (bus_wr && mode == azr_pkg::AZR_RELAY_ONE && bus_addr != dev_addr |=> $stable(s.relay))
    else $error("single module took foreign address");
endmodule // azr_encoder

//--- tb/azr_panel_model.sv
// Purpose: panel side of the relay bus, issues relay writes and traffic
// Assumes: writes launched just after a rising edge, one at a time
// Notes: released lines show inverted values so stale data cannot pass
`timescale 1ns/1ns
module azr_panel_model #(
  parameter int MODULES = 1
) (
  input wire logic clk,
  input wire logic [4:0] base,
  input wire logic quiet,
  output logic [4:0] bus_addr,
  output logic bus_wr,
  output logic [3:0] bus_data,
  output logic bus_activity
);
  initial begin
    bus_addr = 5'h00;
    bus_wr = 1'b0;
    bus_data = 4'h0;
    bus_activity = 1'b1;
  end
  always @(posedge clk) begin
    bus_activity <= !quiet;
  end
  // ********************************
  // relay write
  // ********************************
  task automatic write(input int m, input logic [3:0] d);
    // only the module count the panel was set up for is addressed
    if (m < MODULES) begin
      @(posedge clk);
      bus_addr <= base + 5'(m);
      bus_data <= d;
      bus_wr <= 1'b1;
      @(posedge clk);
      bus_wr <= 1'b0;
      bus_addr <= ~(base + 5'(m));
      bus_data <= ~d;
    end
  endtask
endmodule // azr_panel_model

//--- tb/azr_encoder_bench.sv
// Purpose: self-checking bench for the zone report encoder
// Assumes: shortened counts, relay traffic from the panel model
// Notes: arm-only is not exercised, arm_only stays 0 and no design assertion checks it
`timescale 1ns/1ns
module azr_encoder_bench;
  logic clk, sys_rst, panel_lost, tamper, link_lost, not_registered, shutdown, por_clear;
  logic shared_in, panic_en, bus_wr, bus_activity, tamper_rpt_en, quiet;
  logic status_valid, event_valid, hs_valid, sup_fault;
  azr_pkg::azr_mode_type mode;
  logic [4:0] zone_in, dev_addr, bus_addr;
  logic [3:0] bus_data;
  logic [7:0] restore_en, arm_only;
  logic [31:0] zone_delay;
  logic [15:0] disp, event_code;
  logic [35:0] hs_msg;
  int fails, checked, seed, z, i, n;
  logic [4:0] conds [8] = '{5'h05, 5'h04, 5'h08, 5'h08, 5'h04, 5'h02, 5'h01, 5'h1F};
  logic [15:0] codes [8] = '{16'h0C8F, 16'h0C80, 16'h0400, 16'h0000, 16'h0880, 16'h0005, 16'h000F, 16'h0019};
  azr_encoder #(.SEC_P(10), .MOMENT_P(8), .SUP_P(50), .PULSE_P(6), .GAP_P(12)) dut (
    .clk(clk), .sys_rst(sys_rst), .mode(mode), .panel_lost(panel_lost), .tamper(tamper),
    .link_lost(link_lost), .not_registered(not_registered), .shutdown(shutdown), .por_clear(por_clear),
    .shared_in(shared_in), .zone_in(zone_in), .panic_en(panic_en), .dev_addr(dev_addr),
    .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_data(bus_data), .bus_activity(bus_activity),
    .restore_en(restore_en), .arm_only(arm_only), .zone_delay(zone_delay), .tamper_rpt_en(tamper_rpt_en),
    .long_range_status_display(disp), .status_valid(status_valid), .event_code(event_code),
    .event_valid(event_valid), .hs_msg(hs_msg), .hs_valid(hs_valid), .sup_fault(sup_fault));
  azr_panel_model #(.MODULES(2)) panel (.clk(clk), .base(dev_addr), .quiet(quiet),
    .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_data(bus_data), .bus_activity(bus_activity));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ********************************
  // helpers
  // ********************************
  function automatic logic [35:0] msg(input int zn, input logic [3:0] d);
    logic [35:0] m;
    m = 36'h5555_5555_7;
    m[35 - 4 * zn -: 4] = d;
    return m;
  endfunction
  task check(input logic [35:0] got, input logic [35:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // messages are one-cycle pulses, so the wait samples every cycle
  task automatic wait_msg(input logic [35:0] exp);
    int k;
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (hs_valid !== 1'b1 && k < 200);
    check({35'h0, hs_valid}, 36'h1);
    check(hs_msg, exp);
  endtask
  task automatic no_msg(input int c);
    int k;
    k = 0;
    repeat (c) begin
      @(posedge clk);
      #1;
      if (hs_valid === 1'b1) k++;
    end
    check(36'(k), 36'h0);
  endtask
  task pulse(input int h, input int l);
    @(posedge clk);
    shared_in <= 1'b1;
    repeat (h) @(posedge clk);
    shared_in <= 1'b0;
    repeat (l) @(posedge clk);
  endtask
  task stop_test;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #(100 * 20000);
    fails++;
    stop_test;
  end
  // ********************************
  // main sequence
  // ********************************
  initial begin
    seed = 36172;
    fails = 0;
    checked = 0;
    sys_rst = 1'b1;
    mode = azr_pkg::AZR_KEYPAD;
    {shutdown, panel_lost, tamper, link_lost, not_registered} = 5'h00;
    {por_clear, shared_in, panic_en, tamper_rpt_en, quiet} = 5'h00;
    zone_in = 5'h00;
    dev_addr = 5'h00;
    restore_en = 8'hFF;
    arm_only = 8'h00;
    zone_delay = 32'h0000_0000;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    for (i = 0; i < 8; i++) begin
      @(posedge clk);
      {shutdown, panel_lost, tamper, link_lost, not_registered} <= conds[i];
      por_clear <= (i >= 3);
      n = 0;
      do begin
        @(posedge clk);
        #1;
        n++;
      end while (event_valid !== 1'b1 && n < 4);
      check({19'h0, event_valid, event_code}, {19'h0, 1'b1, codes[i]});
      check({19'h0, status_valid, disp}, {19'h0, 1'b1, codes[i]});
    end
    @(posedge clk);
    {shutdown, panel_lost, tamper, link_lost, not_registered} <= 5'h00;
    mode <= azr_pkg::AZR_ZONE_TRIG;
    fork
      wait_msg(msg(1, 4'h1));
      pulse(20, 0);
    join
    wait_msg(msg(1, 4'h3));
    repeat (20) @(posedge clk);
    fork
      wait_msg(msg(0, 4'h1));
      repeat (3) pulse(2, 3);
    join
    repeat (30) @(posedge clk);
    panic_en <= 1'b1;
    fork
      wait_msg(msg(2, 4'h1));
      pulse(2, 3);
    join
    no_msg(60);
    @(posedge clk);
    panic_en <= 1'b0;
    z = {$random(seed)} % 5;
    zone_in <= 5'(1 << z);
    wait_msg(msg(z + 2, 4'h1));
    zone_in <= 5'h00;
    repeat (40) @(posedge clk);
    mode <= azr_pkg::AZR_RELAY_ONE;
    dev_addr <= 5'({$random(seed)} % 30);
    z = {$random(seed)} % 3;
    @(posedge clk);
    panel.write(0, 4'(1 << z));
    wait_msg(msg(z, 4'h1));
    repeat (30) @(posedge clk);
    panel.write(0, 4'h0);
    wait_msg(msg(z, 4'h3));
    fork
      wait_msg(msg(z, 4'h1));
      begin
        panel.write(0, 4'(1 << z));
        panel.write(0, 4'h0);
      end
    join
    no_msg(40);
    panel.write(1, 4'h1);
    no_msg(20);
    mode <= azr_pkg::AZR_RELAY_TWO;
    panel.write(1, 4'h1);
    wait_msg(msg(4, 4'h1));
    // zone 8 raised with tamper reporting on: only the delayed zone 6 report may appear
    tamper_rpt_en <= 1'b1;
    zone_delay <= 32'h0020_0000;
    panel.write(1, 4'hB);
    no_msg(5);
    wait_msg(msg(5, 4'h1));
    no_msg(20);
    // drop zone 8 while still hidden so no restore is queued
    panel.write(1, 4'h3);
    @(posedge clk);
    tamper_rpt_en <= 1'b0;
    panel.write(1, 4'hB);
    wait_msg(msg(7, 4'h1));
    @(posedge clk);
    quiet <= 1'b1;
    wait_msg(azr_pkg::SUP_TROUBLE);
    check({35'h0, sup_fault}, 36'h1);
    quiet <= 1'b0;
    wait_msg(azr_pkg::SUP_RESTORE);
    stop_test;
  end
endmodule // azr_encoder_bench
